// file: design/sfs_front_end.sv
/*
  Serial front end of a small serial flash: selection, bit sampling and
  launch, opcode capture and rejection, pause, status write guarding.
  Assumes all pins are asynchronous to ref_clk_in, which runs well above
  the serial clock, and that user logic answers opcode_bad_in in the same
  cycle as opcode_strobe_out.
*/
// Function
// - Selected and active only while select low
// - Sample serial input on SCK rising edge
// - Launch output bit after SCK falling edge
// - Work with SCK idling low or high
// - SCK is input only, always slave
// - First byte after select is opcode
// - Bad opcode: ignore input, output off
// - Deselected: ignore input, output off
// - Pause only while selected
// - Pause starts when SCK low after fall
// - Pause ends when SCK low after rise
// - Paused: output off, inputs ignored, state kept
// - Resume at the exact interrupted bit
// - Guard low and enable set: refuse writes
// - Guard low during write aborts it
// - Guard ignored once write cycle began
// - Enable bit clear: guard pin ignored
// - All bytes shifted MSB first
// - Guard enable is status bit seven
`timescale 1ns/100ps
`default_nettype none
module sfs_front_end
  import sfs_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic chip_select_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic pause_n_in,
  input wire logic write_guard_n_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_enable_in,
  input wire logic opcode_bad_in,
  output logic so_out,
  output logic so_oe_out,
  output logic [7:0] rx_byte_out,
  output logic rx_strobe_out,
  output logic opcode_strobe_out,
  output logic paused_out,
  output logic selected_out,
  output logic [7:0] status_out,
  output logic sr_write_done_out
);
  logic [SFS_PIN_W-1:0] sync1;
  logic [SFS_PIN_W-1:0] sync2;
  logic cs_prev, sck_prev;
  logic cs_n, sck, si_s, pause_s, guard_s;
  logic sel, cs_fall, cs_rise, sck_rise, sck_fall, active, guarded;
  sfs_phase_t phase, next_phase;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_shift, next_rx_shift;
  logic [7:0] tx_shift, next_tx_shift;
  logic [7:0] sr, next_sr;
  logic [7:0] sr_data, next_sr_data;
  logic [7:0] next_rx_byte;
  logic drive, next_drive, paused, next_paused, so, next_so;
  logic check, next_check, is_wr, next_is_wr;
  logic sr_pend, next_sr_pend, sr_abort, next_sr_abort;
  logic next_rx_strobe, next_op_strobe, next_done, next_oe;

  // Two flops per pin; only the second stage is ever decoded
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      sync1 <= {2'h3, 3'h1}; // Select high, clock low, pause and guard idle high
      sync2 <= {2'h3, 3'h1};
    end
    else
    begin
      sync1 <= {write_guard_n_in, pause_n_in, si_in, sck_in, chip_select_n_in};
      sync2 <= sync1;
    end
  end

  assign cs_n = sync2[SFS_PIN_CS];
  assign sck = sync2[SFS_PIN_SCK]; // SCK is only ever sampled, never driven
  assign si_s = sync2[SFS_PIN_SI];
  assign pause_s = sync2[SFS_PIN_PAUSE];
  assign guard_s = sync2[SFS_PIN_GUARD];

  // Edge finders; either idle level of SCK works since only edges count
  assign sel = !cs_n;
  assign cs_fall = cs_prev && !cs_n;
  assign cs_rise = !cs_prev && cs_n;
  assign sck_rise = sck && !sck_prev && !paused;
  assign sck_fall = !sck && sck_prev && !paused && !next_paused;
  assign active = sel && (phase == SFS_OPCODE || phase == SFS_DATA);
  assign guarded = !guard_s && sr[SFS_GUARD_BIT];

  // Pause follows the pin only while SCK is low, so an edge seen with
  // SCK high takes effect at the next SCK low
  always_comb
  begin
    next_paused = 1'h0;
    if (sel)
    begin
      next_paused = sck ? paused : !pause_s;
    end
  end

  // Transfer sequencing, shifting and status write handling
  always_comb
  begin
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_drive = drive;
    next_so = so;
    next_check = 1'h0;
    next_is_wr = is_wr;
    next_sr = sr;
    next_sr_data = sr_data;
    next_sr_pend = sr_pend;
    next_sr_abort = sr_abort;
    next_rx_byte = rx_byte_out;
    next_rx_strobe = 1'h0;
    next_op_strobe = 1'h0;
    next_done = 1'h0;
    if (cs_fall)
    begin
      // Fresh selection always starts at opcode bit seven
      next_phase = SFS_OPCODE;
      next_bit_cnt = 3'h0;
      next_drive = 1'h0;
      next_is_wr = 1'h0;
      next_sr_pend = 1'h0;
      next_sr_abort = 1'h0;
    end
    else if (cs_rise)
    begin
      next_phase = SFS_IDLE;
      next_drive = 1'h0;
      // Internal write cycle begins here; guard no longer looked at
      if (sr_pend && !sr_abort)
      begin
        next_sr = (sr & ~SFS_SR_WMASK) | (sr_data & SFS_SR_WMASK);
        next_done = 1'h1;
      end
      next_sr_pend = 1'h0;
    end
    else
    begin
      if (active && sck_rise)
      begin
        next_rx_shift = {rx_shift[6:0], si_s};
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == SFS_LAST_BIT)
        begin
          next_rx_byte = {rx_shift[6:0], si_s};
          next_rx_strobe = 1'h1;
          next_tx_shift = tx_byte_in;
          next_drive = tx_enable_in;
          if (phase == SFS_OPCODE)
          begin
            next_op_strobe = 1'h1;
            next_check = 1'h1;
            next_phase = SFS_DATA;
            next_is_wr = ({rx_shift[6:0], si_s} == SFS_SR_WRITE_OP);
          end
          else if (is_wr && !sr_pend)
          begin
            next_sr_data = {rx_shift[6:0], si_s};
            next_sr_pend = 1'h1;
          end
        end
      end
      if (active && sck_fall && drive)
      begin
        next_so = tx_shift[7];
        next_tx_shift = {tx_shift[6:0], 1'h0};
      end
      // Rejection beats any launch prepared in the same cycle
      if (check && opcode_bad_in)
      begin
        next_phase = SFS_REJECT;
        next_drive = 1'h0;
      end
      // Abort is sticky for the rest of the selection
      if (sel && next_is_wr && guarded)
      begin
        next_sr_abort = 1'h1;
      end
    end
    // Held off while the opcode is judged, so a rejected one never drives the pin
    next_oe = sel && !next_paused && next_drive && !next_check
      && (next_phase == SFS_DATA);
  end

  // State registers
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      cs_prev <= 1'h1;
      sck_prev <= 1'h0;
      phase <= SFS_IDLE;
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      drive <= 1'h0;
      so <= 1'h0;
      paused <= 1'h0;
      check <= 1'h0;
      is_wr <= 1'h0;
      sr <= SFS_SR_RESET;
      sr_data <= 8'h00;
      sr_pend <= 1'h0;
      sr_abort <= 1'h0;
      so_oe_out <= 1'h0;
      rx_byte_out <= 8'h00;
      rx_strobe_out <= 1'h0;
      opcode_strobe_out <= 1'h0;
      paused_out <= 1'h0;
      selected_out <= 1'h0;
      sr_write_done_out <= 1'h0;
    end
    else
    begin
      cs_prev <= cs_n;
      sck_prev <= sck;
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      drive <= next_drive;
      so <= next_so;
      paused <= next_paused;
      check <= next_check;
      is_wr <= next_is_wr;
      sr <= next_sr;
      sr_data <= next_sr_data;
      sr_pend <= next_sr_pend;
      sr_abort <= next_sr_abort;
      so_oe_out <= next_oe;
      rx_byte_out <= next_rx_byte;
      rx_strobe_out <= next_rx_strobe;
      opcode_strobe_out <= next_op_strobe;
      paused_out <= next_paused;
      selected_out <= sel;
      sr_write_done_out <= next_done;
    end
  end

  // Output pin mirrors internal registers
  assign so_out = so;
  assign status_out = sr;

  // Checks on the pin behaviour and sequencing
  a_desel_output_off: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cs_n |=> !so_oe_out) else $error("output enabled while deselected");
  a_pause_output_off: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    paused |-> !so_oe_out) else $error("output enabled while paused");
  a_reject_output_off: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (phase == SFS_REJECT && sel) |=> (phase == SFS_REJECT || cs_n) && !so_oe_out)
    else $error("rejected transfer resumed or drove output");
  a_fall_clears_count: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cs_fall |=> bit_cnt == 3'h0 && phase == SFS_OPCODE) else $error("counters not cleared");
  a_pause_freeze_state: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    paused && $past(paused) |-> $stable(bit_cnt) && $stable(rx_shift) && $stable(so))
    else $error("state moved during pause");
  a_pause_entry_low: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sel && !sck && !pause_s |=> paused) else $error("pause not entered with clock low");
  a_pause_exit_low: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sel && !sck && pause_s |=> !paused) else $error("pause not left with clock low");
  a_rise_sample_bit: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    active && sck_rise && !cs_fall |=> rx_shift[0] == $past(si_s) && bit_cnt == $past(bit_cnt) + 3'h1)
    else $error("input bit not sampled on rising edge");
  a_guard_aborts_wr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sel && is_wr && guarded && !cs_fall |=> sr_abort ##1 !sr_write_done_out)
    else $error("guarded status write not aborted");

  // Launch timing, byte framing and status commit points
  a_launch_on_fall: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    so != $past(so) |-> $past(active && sck_fall && drive))
    else $error("output bit changed without a clock fall");
  a_opcode_then_data: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    opcode_strobe_out |-> rx_strobe_out && phase == SFS_DATA)
    else $error("opcode byte did not open the data phase");
  a_idle_no_pause: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !sel |=> !paused)
    else $error("pause entered while deselected");
  a_rx_msb_first: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    rx_strobe_out |-> rx_byte_out[7:1] == $past(rx_shift[6:0]))
    else $error("received byte not assembled first bit high");
  a_status_commit_only: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sr != $past(sr) |-> $past(cs_rise && sr_pend && !sr_abort))
    else $error("status changed outside a write commit");
  a_guard_off_commits: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cs_rise && sr_pend && !sr[SFS_GUARD_BIT] |=> sr_write_done_out)
    else $error("unguarded status write not committed");
endmodule
`default_nettype wire

// file: design/sfs_pkg.sv
/*
  Shared constants and types of the serial flash front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sfs_pkg;
  // Pin slots in the input synchroniser
  localparam int SFS_PIN_W = 5;
  localparam int SFS_PIN_CS = 0;
  localparam int SFS_PIN_SCK = 1;
  localparam int SFS_PIN_SI = 2;
  localparam int SFS_PIN_PAUSE = 3;
  localparam int SFS_PIN_GUARD = 4;
  // Status register layout
  localparam int SFS_GUARD_BIT = 7;
  localparam logic [7:0] SFS_SR_RESET = 8'h00;
  localparam logic [7:0] SFS_SR_WMASK = 8'h8C;
  localparam logic [7:0] SFS_SR_WRITE_OP = 8'h01;
  localparam logic [2:0] SFS_LAST_BIT = 3'h7;
  // Transfer phase
  typedef enum logic [1:0] {
    SFS_IDLE = 2'b00,
    SFS_OPCODE = 2'b01,
    SFS_DATA = 2'b10,
    SFS_REJECT = 2'b11
  } sfs_phase_t;
endpackage

// file: sim/sfs_spi_master.sv
/*
  Bus master model for the flash front end.
  Assumes the bench clock; every pin moves on its falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_spi_master (
  input wire logic ref_clk_in,
  input wire logic so_in,
  output logic chip_select_n_out,
  output logic sck_out,
  output logic si_out,
  output logic pause_n_out,
  output logic write_guard_n_out
);
  logic cpol = 1'b0;
  // Deselected with pause and guard released
  initial
  begin
    chip_select_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    pause_n_out = 1'b1;
    write_guard_n_out = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic pins(input logic p, input logic g);
    pause_n_out = p;
    write_guard_n_out = g;
  endtask
  // Idle level is set before select, so no stray edge
  task automatic select(input logic mode);
    cpol = mode;
    sck_out = mode;
    hw(8);
    chip_select_n_out = 1'b0;
    hw(8);
  endtask
  // Fall launches, rise samples; 16 clocks per bit
  task automatic bit_x(input logic b, output logic r);
    sck_out = 1'b0;
    si_out = b;
    hw(8);
    sck_out = 1'b1;
    r = so_in;
    hw(8);
  endtask
  task automatic byte_x(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(b[i], r[i]);
    end
  endtask
  // Clock back to idle first; never called while paused
  task automatic deselect();
    if (!cpol)
    begin
      sck_out = 1'b0;
    end
    hw(8);
    chip_select_n_out = 1'b1;
    hw(8);
  endtask
endmodule
`default_nettype wire

// file: sim/test_sfs_front_end.sv
/*
  Self-checking bench of the flash front end.
  Assumes the master model owns the pins; user side driven here.
*/
`timescale 1ns/100ps
`default_nettype none
module test_sfs_front_end
  import sfs_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic tx_enable_in = 1'b1;
  logic opcode_bad_in = 1'b0;
  logic so_prev = 1'b0;
  logic [7:0] tx_byte = 8'hA5;
  wire logic cs_n, sck, si, pause_n, guard_n, so_out, so_oe_out, so_line;
  wire logic rx_strobe_out, opcode_strobe_out, paused_out, sr_write_done_out, selected_out;
  wire logic [7:0] rx_byte_out, status_out;
  int n_mismatch, checked, n_rx, n_op, n_done, n_oe, cycles;
  // Released line shows the inverse of its last value
  assign so_line = so_oe_out ? so_out : ~so_prev;
  sfs_front_end i_sfs_front_end (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .chip_select_n_in(cs_n), .sck_in(sck), .si_in(si), .pause_n_in(pause_n),
    .write_guard_n_in(guard_n), .tx_byte_in(tx_byte), .tx_enable_in(tx_enable_in),
    .opcode_bad_in(opcode_bad_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .rx_byte_out(rx_byte_out), .rx_strobe_out(rx_strobe_out),
    .opcode_strobe_out(opcode_strobe_out), .paused_out(paused_out),
    .selected_out(selected_out), .status_out(status_out),
    .sr_write_done_out(sr_write_done_out));
  sfs_spi_master i_sfs_spi_master (.ref_clk_in(ref_clk_in), .so_in(so_line),
    .chip_select_n_out(cs_n), .sck_out(sck), .si_out(si), .pause_n_out(pause_n),
    .write_guard_n_out(guard_n));
  initial
  begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // Pulse counters and hang guard
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (so_oe_out === 1'b1) so_prev <= so_out;
    if (so_oe_out === 1'b1) n_oe++;
    if (rx_strobe_out === 1'b1) n_rx++;
    if (opcode_strobe_out === 1'b1) n_op++;
    if (sr_write_done_out === 1'b1) n_done++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic sc_read(input logic mode, input logic [7:0] tx, input logic en);
    int o0;
    int e0;
    logic [7:0] r;
    o0 = n_op;
    e0 = n_oe;
    tx_byte = tx;
    tx_enable_in = en;
    i_sfs_spi_master.select(mode);
    check("selected", {7'h00, selected_out}, 8'h01);
    i_sfs_spi_master.byte_x(8'h05, r);
    check("opcode", rx_byte_out, 8'h05);
    i_sfs_spi_master.byte_x(8'h00, r);
    if (en) check("read data", r, tx);
    check("output used", {7'h00, n_oe != e0}, {7'h00, en});
    check("opcode count", 8'(n_op - o0), 8'h01);
    i_sfs_spi_master.deselect();
    check("idle oe", {7'h00, so_oe_out}, 8'h00);
    check("deselected", {7'h00, selected_out}, 8'h00);
  endtask
  task automatic sc_reject();
    int r0;
    int e0;
    logic [7:0] r;
    e0 = n_oe;
    tx_enable_in = 1'b1;
    opcode_bad_in = 1'b1;
    i_sfs_spi_master.select(1'b0);
    i_sfs_spi_master.byte_x(8'hFF, r);
    r0 = n_rx;
    i_sfs_spi_master.byte_x(8'h3C, r);
    check("rejected bytes", 8'(n_rx - r0), 8'h00);
    check("rejected oe", {7'h00, so_oe_out}, 8'h00);
    check("rejected drive", {7'h00, n_oe != e0}, 8'h00);
    i_sfs_spi_master.deselect();
    opcode_bad_in = 1'b0;
  endtask
  // Pause and release both land while the clock is high
  task automatic sc_pause();
    int r0;
    logic [7:0] r;
    logic j;
    logic [7:0] pat;
    pat = 8'h6A;
    r0 = n_rx;
    i_sfs_spi_master.select(1'b0);
    for (int i = 7; i >= 4; i--)
    begin
      i_sfs_spi_master.bit_x(pat[i], r[i]);
    end
    i_sfs_spi_master.pins(1'b0, 1'b1);
    i_sfs_spi_master.hw(6);
    check("pause early", {7'h00, paused_out}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      i_sfs_spi_master.bit_x(1'b1, j);
    end
    check("paused", {7'h00, paused_out}, 8'h01);
    i_sfs_spi_master.pins(1'b1, 1'b1);
    i_sfs_spi_master.hw(6);
    check("pause held", {7'h00, paused_out}, 8'h01);
    for (int i = 3; i >= 0; i--)
    begin
      i_sfs_spi_master.bit_x(pat[i], r[i]);
    end
    check("resumed byte", rx_byte_out, 8'h6A);
    check("byte count", 8'(n_rx - r0), 8'h01);
    i_sfs_spi_master.deselect();
  endtask
  task automatic sc_write(input logic [7:0] d, input logic g, input logic [7:0] e,
    input logic ok);
    int d0;
    logic [7:0] r;
    d0 = n_done;
    i_sfs_spi_master.pins(1'b1, g);
    i_sfs_spi_master.select(1'b0);
    i_sfs_spi_master.byte_x(SFS_SR_WRITE_OP, r);
    i_sfs_spi_master.byte_x(d, r);
    i_sfs_spi_master.deselect();
    check("status", status_out, e);
    check("write done", 8'(n_done - d0), {7'h00, ok});
    i_sfs_spi_master.pins(1'b1, 1'b1);
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    check("status reset", status_out, SFS_SR_RESET);
    sc_read(1'b0, 8'hA5, 1'b1);
    sc_read(1'b1, 8'h3C, 1'b1);
    sc_read(1'b0, 8'h5A, 1'b0);
    sc_reject();
    sc_pause();
    sc_write(8'hFF, 1'b1, 8'h8C, 1'b1);
    sc_write(8'h00, 1'b0, 8'h8C, 1'b0);
    sc_write(8'h0C, 1'b1, 8'h0C, 1'b1);
    sc_write(8'h84, 1'b0, 8'h84, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
